// ---- common/jtag_cfg.svh ----
// numeric constants of the boundary-scan test port
`ifndef JTAG_CFG_SVH
`define JTAG_CFG_SVH
`define IR_W 5
`define IR_EXTEST 5'h00
`define IR_SAMPLE 5'h01
`define IR_RING 5'h02
`define IR_DELAY 5'h03
`define IR_CLAMP 5'h04
`define IR_HIGHZ 5'h05
`define IR_BYPASS 5'h1F
`define IR_CAPTURE 5'h01
`define REQ_N 9
`define GNT_N 3
`define GRP_N 9
`define REQ_BASE 0
`define GNT_BASE 9
`define GRP_BASE 12
`define GNT_GROUP 5
`define CHAIN_LEN 21
`define CELL_RESET 1'h1
`endif

// ---- common/jtag_pkg.sv ----
// types shared by the test port controller
`include "jtag_cfg.svh"
package jtag_pkg;
  // controller states, binary coded
  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000,
    TAP_IDLE = 4'b0001,
    SEL_DR = 4'b0010,
    CAP_DR = 4'b0011,
    SHIFT_DR = 4'b0100,
    EXIT1_DR = 4'b0101,
    PAUSE_DR = 4'b0110,
    EXIT2_DR = 4'b0111,
    UPD_DR = 4'b1000,
    SEL_IR = 4'b1001,
    CAP_IR = 4'b1010,
    SHIFT_IR = 4'b1011,
    EXIT1_IR = 4'b1100,
    PAUSE_IR = 4'b1101,
    EXIT2_IR = 4'b1110,
    UPD_IR = 4'b1111
  } tap_state_t;

  // whole register state of the top module
  typedef struct packed {
    logic tckS1;
    logic tckS2;
    logic tckPrev;
    logic tmsS1;
    logic tmsS2;
    logic tdiS1;
    logic tdiS2;
    logic trstNS1;
    logic trstNS2;
    logic [`REQ_N-1:0] reqS1;
    logic [`REQ_N-1:0] reqS2;
    logic [`GNT_N-1:0] gntInS1;
    logic [`GNT_N-1:0] gntInS2;
    tap_state_t tap;
    logic [`IR_W-1:0] irShift;
    logic [`IR_W-1:0] irLatch;
    logic bypassBit;
    logic tdo;
    logic tdoOeN;
    logic [`GNT_N-1:0] gntOut;
    logic [`GNT_N-1:0] gntOeN;
    logic [`GRP_N-1:0] groupOff;
  } port_state_t;
endpackage

// ---- common/chain_if.sv ----
// control and data between the controller and the boundary chain
`timescale 1ns/10ps
`default_nettype none
`include "jtag_cfg.svh"
interface chain_if #(parameter int LEN = `CHAIN_LEN);
  logic captureEn;
  logic shiftEn;
  logic ringEn;
  logic updateEn;
  logic scanIn;
  logic [LEN-1:0] captureBits;
  logic scanOut;
  logic [LEN-1:0] updBits;
  modport ctl (
    output captureEn, shiftEn, ringEn, updateEn, scanIn, captureBits,
    input scanOut, updBits
  );
  modport cells (
    input captureEn, shiftEn, ringEn, updateEn, scanIn, captureBits,
    output scanOut, updBits
  );
endinterface
`default_nettype wire

// ---- verilog/scan_cell_chain.sv ----
// boundary chain: shift stage plus update latch for every cell
`timescale 1ns/10ps
`default_nettype none
`include "jtag_cfg.svh"
module scan_cell_chain #(
  parameter int LEN = `CHAIN_LEN
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // controller side
  chain_if.cells chain
);
  typedef struct packed {
    logic [LEN-1:0] shiftBits;
    logic [LEN-1:0] updBits;
  } cells_t;

  cells_t q;
  cells_t d;

  // one capture, shift or ring step per enable; update copies the stage
  always_comb begin
    d = q;
    if (chain.captureEn) begin
      d.shiftBits = chain.captureBits; // [R12] [R13] [R14]
    end else if (chain.shiftEn) begin
      d.shiftBits = {chain.scanIn, q.shiftBits[LEN-1:1]}; // [R19]
    end else if (chain.ringEn) begin
      d.shiftBits = {q.shiftBits[0], q.shiftBits[LEN-1:1]}; // [R5]
    end
    if (chain.updateEn) begin
      d.updBits = q.shiftBits; // [R13] [R14]
    end
  end

  // update latch resets to ones so group controls start floated
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q.shiftBits <= {LEN{`CELL_RESET}};
      q.updBits <= {LEN{`CELL_RESET}};
    end else begin
      q <= d;
    end
  end

  assign chain.scanOut = q.shiftBits[0]; // [R19]
  assign chain.updBits = q.updBits;
endmodule
`default_nettype wire

// ---- verilog/boundary_scan_test_port.sv ----
// boundary-scan test access port: controller, instruction, bypass, pins
//
// Functional notes
// R1 - tms at tck rise steers controller
// R2 - state actions start on tck rise
// R3 - five-bit instruction picks mode and path
// R4 - 00000 drives pins, 00001 samples pins
// R5 - 00010 rings the boundary chain
// R6 - 00011 sets chain for delay measurement
// R7 - clamp drives pins, bypass shifts
// R8 - highz floats all outputs but tdo
// R9 - codes 00110 upward act as bypass
// R10 - instruction shifts in, latched in parallel
// R11 - bypass is one flip-flop tdi to tdo
// R12 - input cell captures pin and shifts
// R13 - output cell captures, shifts, drives pin
// R14 - bidirectional cell captures incoming pin data
// R15 - group bit 0 enables, 1 floats
// R16 - nine group-disable bits in chain
// R17 - group bits affect drivers only
// R18 - each group bit has chain position
// R19 - chain enters at msb, leaves lsb
// R20 - requests first, then grants under group five
// R21 - tester uses port only when idle
// R22 - low test reset resets the controller
// R23 - sixteen states, five tms highs reset
// R24 - tdo changes on fall, shift only
`timescale 1ns/10ps
`default_nettype none
`include "jtag_cfg.svh"
module boundary_scan_test_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trstN,
  output logic tdoOut,
  output logic tdoOeN,
  // secondary request input pins
  input wire logic [`REQ_N-1:0] reqPin,
  // secondary grant pins and functional grant values
  input wire logic [`GNT_N-1:0] gntCore,
  input wire logic [`GNT_N-1:0] gntPinIn,
  output logic [`GNT_N-1:0] gntPinOut,
  output logic [`GNT_N-1:0] gntPinOeN,
  // driver group disables and active instruction
  output logic [`GRP_N-1:0] groupOff,
  output logic [`IR_W-1:0] activeInstr
);

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // next controller state from the sampled tms level
  function automatic jtag_pkg::tap_state_t nextTap(
    input jtag_pkg::tap_state_t cur,
    input logic tmsBit
  );
    jtag_pkg::tap_state_t nxt;
    nxt = cur;
    case (cur)
      jtag_pkg::TAP_RESET: begin
        nxt = tmsBit ? jtag_pkg::TAP_RESET : jtag_pkg::TAP_IDLE;
      end
      jtag_pkg::TAP_IDLE: begin
        nxt = tmsBit ? jtag_pkg::SEL_DR : jtag_pkg::TAP_IDLE;
      end
      jtag_pkg::SEL_DR: begin
        nxt = tmsBit ? jtag_pkg::SEL_IR : jtag_pkg::CAP_DR;
      end
      jtag_pkg::CAP_DR: begin
        nxt = tmsBit ? jtag_pkg::EXIT1_DR : jtag_pkg::SHIFT_DR;
      end
      jtag_pkg::SHIFT_DR: begin
        nxt = tmsBit ? jtag_pkg::EXIT1_DR : jtag_pkg::SHIFT_DR;
      end
      jtag_pkg::EXIT1_DR: begin
        nxt = tmsBit ? jtag_pkg::UPD_DR : jtag_pkg::PAUSE_DR;
      end
      jtag_pkg::PAUSE_DR: begin
        nxt = tmsBit ? jtag_pkg::EXIT2_DR : jtag_pkg::PAUSE_DR;
      end
      jtag_pkg::EXIT2_DR: begin
        nxt = tmsBit ? jtag_pkg::UPD_DR : jtag_pkg::SHIFT_DR;
      end
      jtag_pkg::UPD_DR: begin
        nxt = tmsBit ? jtag_pkg::SEL_DR : jtag_pkg::TAP_IDLE;
      end
      jtag_pkg::SEL_IR: begin
        nxt = tmsBit ? jtag_pkg::TAP_RESET : jtag_pkg::CAP_IR;
      end
      jtag_pkg::CAP_IR: begin
        nxt = tmsBit ? jtag_pkg::EXIT1_IR : jtag_pkg::SHIFT_IR;
      end
      jtag_pkg::SHIFT_IR: begin
        nxt = tmsBit ? jtag_pkg::EXIT1_IR : jtag_pkg::SHIFT_IR;
      end
      jtag_pkg::EXIT1_IR: begin
        nxt = tmsBit ? jtag_pkg::UPD_IR : jtag_pkg::PAUSE_IR;
      end
      jtag_pkg::PAUSE_IR: begin
        nxt = tmsBit ? jtag_pkg::EXIT2_IR : jtag_pkg::PAUSE_IR;
      end
      jtag_pkg::EXIT2_IR: begin
        nxt = tmsBit ? jtag_pkg::UPD_IR : jtag_pkg::SHIFT_IR;
      end
      jtag_pkg::UPD_IR: begin
        nxt = tmsBit ? jtag_pkg::SEL_DR : jtag_pkg::TAP_IDLE;
      end
      // unknown codes fall back to test-logic-reset so a glitch cannot lock the port
      default: begin
        nxt = jtag_pkg::TAP_RESET;
      end
    endcase
    return nxt;
  endfunction

  // boundary chain is the data path for the four lowest codes only
  function automatic logic chainSelected(input logic [`IR_W-1:0] ir);
    return (ir == `IR_EXTEST) || (ir == `IR_SAMPLE) ||
           (ir == `IR_RING) || (ir == `IR_DELAY);
  endfunction

  // pins follow the update latch in these modes
  function automatic logic pinsFromChain(input logic [`IR_W-1:0] ir);
    return (ir == `IR_EXTEST) || (ir == `IR_DELAY) || (ir == `IR_CLAMP);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state and chain

  jtag_pkg::port_state_t q;
  jtag_pkg::port_state_t d;

  // chain control and data travel in one bundle to the cell module
  chain_if #(.LEN(`CHAIN_LEN)) chain ();

  scan_cell_chain #(
    .LEN(`CHAIN_LEN)
  ) cells (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .chain(chain)
  );

  ////////////////////////////////////////////////////////////////////////
  // derived strobes

  logic tckRise;
  logic tckFall;
  logic chainPath;
  logic driveTest;
  logic floatAll;
  logic [`GRP_N-1:0] groupBits;

  // tck phases under one system clock may be lost; the tester must stretch them
  // edges are found on the second sync stage, never the first
  assign tckRise = q.tckS2 & ~q.tckPrev; // [R1]
  assign tckFall = ~q.tckS2 & q.tckPrev; // [R24]

  // decoded instruction: path, pin drive source and float request
  assign chainPath = chainSelected(q.irLatch); // [R3] [R9]
  assign driveTest = pinsFromChain(q.irLatch); // [R4] [R6] [R7]
  assign floatAll = (q.irLatch == `IR_HIGHZ); // [R8]

  // group-disable cells sit in their own chain slots, tied to no pin
  assign groupBits = chain.updBits[`GRP_BASE +: `GRP_N]; // [R16] [R18]

  ////////////////////////////////////////////////////////////////////////
  // boundary chain control

  // every strobe lasts one ref_clk, so one tck rise moves the chain one step
  // capture in capture-dr; delay mode also captures each tck in idle
  assign chain.captureEn = tckRise && chainPath &&
    ((q.tap == jtag_pkg::CAP_DR) ||
     ((q.irLatch == `IR_DELAY) && (q.tap == jtag_pkg::TAP_IDLE))); // [R2] [R6]

  // shift only while the chain is the selected path
  assign chain.shiftEn = tckRise && chainPath &&
    (q.tap == jtag_pkg::SHIFT_DR); // [R2] [R19]

  // ring mode recirculates the chain once per tck in run-test/idle
  assign chain.ringEn = tckRise && (q.irLatch == `IR_RING) &&
    (q.tap == jtag_pkg::TAP_IDLE); // [R5]

  // clamp and highz keep the latch: only chain instructions update it
  assign chain.updateEn = tckRise && chainPath &&
    (q.tap == jtag_pkg::UPD_DR); // [R2] [R4]

  // serial input comes from the synced tdi, in step with the edge detector
  assign chain.scanIn = q.tdiS2;

  // input cells take the request pins, grant cells the incoming pin data;
  // one assignment keeps the capture word a single driver, group slots on top
  assign chain.captureBits = {
    groupBits, // [R18]
    q.gntInS2, // [R14] [R20]
    q.reqS2 // [R12] [R20]
  };

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  // one combinational copy of the whole state, registered below
  always_comb begin
    d = q;
    // two-stage synchronisers for every pin from the tester or board
    d.tckS1 = tck;
    d.tckS2 = q.tckS1;
    d.tckPrev = q.tckS2;
    d.tmsS1 = tms;
    d.tmsS2 = q.tmsS1;
    d.tdiS1 = tdi;
    d.tdiS2 = q.tdiS1;
    d.trstNS1 = trstN;
    d.trstNS2 = q.trstNS1;
    d.reqS1 = reqPin;
    d.reqS2 = q.reqS1;
    d.gntInS1 = gntPinIn;
    d.gntInS2 = q.gntInS1;

    // test reset wins over any tck activity
    if (!q.trstNS2) begin
      d.tap = jtag_pkg::TAP_RESET; // [R22]
      d.irLatch = `IR_BYPASS; // [R22]
    end else if (tckRise) begin
      d.tap = nextTap(q.tap, q.tmsS2); // [R1] [R23]
      // entering test-logic-reset drops the instruction on the same rise
      if (d.tap == jtag_pkg::TAP_RESET) begin
        d.irLatch = `IR_BYPASS; // [R23]
      end
      // work tied to the current state runs on this same rise
      case (q.tap)
        jtag_pkg::TAP_RESET: begin
          d.irLatch = `IR_BYPASS; // [R23]
        end
        jtag_pkg::CAP_IR: begin
          d.irShift = `IR_CAPTURE; // [R2] [R10]
        end
        jtag_pkg::SHIFT_IR: begin
          d.irShift = {q.tdiS2, q.irShift[`IR_W-1:1]}; // [R10]
        end
        jtag_pkg::UPD_IR: begin
          d.irLatch = q.irShift; // [R10] [R3]
        end
        jtag_pkg::CAP_DR: begin
          if (!chainPath) begin
            d.bypassBit = 1'h0; // [R11]
          end
        end
        jtag_pkg::SHIFT_DR: begin
          if (!chainPath) begin
            d.bypassBit = q.tdiS2; // [R11] [R7] [R8] [R9]
          end
        end
        default: begin
        end
      endcase
    end

    // tdo lags the pin fall by about three system clocks, well inside a tck phase
    // tdo moves on the falling edge, driven only while shifting
    if (!q.trstNS2) begin
      d.tdoOeN = 1'h1; // [R24]
    end else if (tckFall) begin
      if (q.tap == jtag_pkg::SHIFT_IR) begin
        d.tdo = q.irShift[0]; // [R24]
        d.tdoOeN = 1'h0; // [R24]
      end else if (q.tap == jtag_pkg::SHIFT_DR) begin
        d.tdo = chainPath ? chain.scanOut : q.bypassBit; // [R19] [R11]
        d.tdoOeN = 1'h0; // [R24]
      end else begin
        d.tdoOeN = 1'h1; // [R24]
      end
    end

    // highz is tested first so no chain value can fight a float request
    // driver groups: highz floats all, extest, delay and clamp follow the cells
    if (floatAll) begin
      d.groupOff = {`GRP_N{1'h1}}; // [R8]
    end else if (driveTest) begin
      d.groupOff = groupBits; // [R15] [R16]
    end else begin
      d.groupOff = {`GRP_N{1'h0}};
    end

    // grant pins: cell value in test drive modes, core value otherwise
    d.gntOut = driveTest ?
      chain.updBits[`GNT_BASE +: `GNT_N] : gntCore; // [R4] [R7] [R13]
    // grants float with group five; request inputs have no control
    d.gntOeN = {`GNT_N{d.groupOff[`GNT_GROUP]}}; // [R15] [R17] [R20]
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // one register bank for the whole port keeps every field on the same edge
  // reset leaves tdo floated, grant and group drivers enabled, and the bypass code latched
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q.tckS1 <= 1'h0;
      q.tckS2 <= 1'h0;
      q.tckPrev <= 1'h0;
      q.tmsS1 <= 1'h1;
      q.tmsS2 <= 1'h1;
      q.tdiS1 <= 1'h1;
      q.tdiS2 <= 1'h1;
      // synced test reset starts low: the controller waits until the pin is seen
      q.trstNS1 <= 1'h0;
      q.trstNS2 <= 1'h0;
      q.reqS1 <= {`REQ_N{1'h1}};
      q.reqS2 <= {`REQ_N{1'h1}};
      q.gntInS1 <= {`GNT_N{1'h1}};
      q.gntInS2 <= {`GNT_N{1'h1}};
      q.tap <= jtag_pkg::TAP_RESET;
      q.irShift <= `IR_CAPTURE;
      q.irLatch <= `IR_BYPASS;
      q.bypassBit <= 1'h0;
      q.tdo <= 1'h1;
      q.tdoOeN <= 1'h1;
      q.gntOut <= {`GNT_N{1'h1}};
      q.gntOeN <= {`GNT_N{1'h0}};
      q.groupOff <= {`GRP_N{1'h0}};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flip-flop

  // the port is only meaningful while the bridge core is quiet
  assign tdoOut = q.tdo;
  assign tdoOeN = q.tdoOeN;
  assign gntPinOut = q.gntOut;
  assign gntPinOeN = q.gntOeN;
  assign groupOff = q.groupOff;
  // activeInstr shows the system which test mode currently owns the pins
  assign activeInstr = q.irLatch;

endmodule
`default_nettype wire

// ---- test/boundary_scan_test_port_props.sv ----
// assertion checker watching the boundary-scan test port pins
`timescale 1ns/10ps
`default_nettype none
`include "jtag_cfg.svh"
module boundary_scan_test_port_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // test port pins
  input wire logic tck,
  input wire logic trstN,
  input wire logic tdoOut,
  input wire logic tdoOeN,
  // grants, groups and instruction
  input wire logic [`GNT_N-1:0] gntCore,
  input wire logic [`GNT_N-1:0] gntPinOut,
  input wire logic [`GNT_N-1:0] gntPinOeN,
  input wire logic [`GRP_N-1:0] groupOff,
  input wire logic [`IR_W-1:0] activeInstr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] trstHist_q;
  logic trstQuiet;
  // test reset history; changes forced by it may come without any tck edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trstHist_q <= 4'h0;
    end else begin
      trstHist_q <= {trstHist_q[2:0], trstN};
    end
  end
  assign trstQuiet = &trstHist_q && trstN;
  // steady test modes, long enough for the pins to follow
  sequence sClamp; (activeInstr == `IR_CLAMP) [*4]; endsequence
  sequence sHighz; (activeInstr == `IR_HIGHZ) [*4]; endsequence
  sequence sFunc; (activeInstr >= 5'h06 && $stable(gntCore)) [*4]; endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_grant_group_tie: assert property (gntPinOeN == {3{groupOff[5]}})
    else $error("grant enables differ from group five");
  a_trst_clears: assert property (!trstN [*4] |-> activeInstr == 5'h1F && tdoOeN)
    else $error("test reset did not clear the port");
  a_tdo_on_fall: assert property ($changed(tdoOut) |-> !$past(tck))
    else $error("tdo moved outside a tck low phase");
  a_oe_on_fall: assert property ($changed(tdoOeN) && trstQuiet |-> !$past(tck))
    else $error("tdo enable moved outside a tck low phase");
  a_instr_on_rise: assert property ($changed(activeInstr) && trstQuiet |-> $past(tck))
    else $error("instruction changed without a tck rise");
  a_pins_on_rise: assert property ($changed(groupOff) && trstQuiet |-> $past(tck, 3))
    else $error("group disables changed without a tck rise");
  a_highz_float: assert property (sHighz |-> &groupOff && &gntPinOeN)
    else $error("driver left enabled in high impedance mode");
  a_clamp_hold: assert property (sClamp |-> $stable(gntPinOut) && $stable(groupOff))
    else $error("pins moved while clamped");
  a_func_grant: assert property (sFunc |-> gntPinOut == gntCore && groupOff == 9'h000)
    else $error("bypass mode does not pass functional grants");
endmodule
bind boundary_scan_test_port boundary_scan_test_port_props u_props (
  .ref_clk(ref_clk), .resetn(resetn), .tck(tck), .trstN(trstN), .tdoOut(tdoOut),
  .tdoOeN(tdoOeN), .gntCore(gntCore), .gntPinOut(gntPinOut), .gntPinOeN(gntPinOeN),
  .groupOff(groupOff), .activeInstr(activeInstr)
);
`default_nettype wire

// ---- test/jtag_tester.sv ----
// model of the external boundary-scan tester driving the test port
`timescale 1ns/10ps
`default_nettype none
module jtag_tester (
  // pacing clock
  input wire logic ref_clk,
  // pins toward the device
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trstN,
  input wire logic tdoOut,
  input wire logic tdoOeN
);
  // tck rests low between frames; only used while functional side is quiet
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trstN = 1'b1;
  end
  // one 320 ns tck period; tms and tdi settle while tck is low
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge ref_clk);
    tms = m;
    tdi = d;
    repeat (3) @(negedge ref_clk);
    // a floated tdo reads as the inverse of its stale value, so a bad sample fails
    o = tdoOeN ? ~tdoOut : tdoOut;
    tck = 1'b1;
    repeat (4) @(negedge ref_clk);
    tck = 1'b0;
    tdi = ~d; // released data line shows no stale value
  endtask
  // test reset pulse of eight system clocks
  task automatic pulse_reset;
    @(negedge ref_clk);
    trstN = 1'b0;
    repeat (8) @(negedge ref_clk);
    trstN = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- test/boundary_scan_test_port_tb.sv ----
// self-checking testbench for the boundary-scan test port
`timescale 1ns/10ps
`default_nettype none
`include "jtag_cfg.svh"
module boundary_scan_test_port_tb;
  logic ref_clk, resetn, tck, tms, tdi, trstN, tdoOut, tdoOeN;
  logic [`REQ_N-1:0] reqPin;
  logic [`GNT_N-1:0] gntCore, gntPinIn, gntPinOut, gntPinOeN;
  logic [`GRP_N-1:0] groupOff;
  logic [`IR_W-1:0] activeInstr;
  logic [31:0] dout;
  int failures, num_checks;
  ////////////////////////////////////////////////////////////////////////////
  boundary_scan_test_port dut (
    .ref_clk(ref_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
    .trstN(trstN), .tdoOut(tdoOut), .tdoOeN(tdoOeN), .reqPin(reqPin),
    .gntCore(gntCore), .gntPinIn(gntPinIn), .gntPinOut(gntPinOut),
    .gntPinOeN(gntPinOeN), .groupOff(groupOff), .activeInstr(activeInstr)
  );
  jtag_tester tester (
    .ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdoOut(tdoOut),
    .tdoOeN(tdoOeN)
  );
  // 25 MHz system clock
  always #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // n tck periods with tms bits taken lsb first
  task automatic walk(input logic [7:0] ms, input int n);
    logic o;
    for (int i = 0; i < n; i++) tester.step(ms[i], 1'b0, o);
  endtask
  // shift n bits lsb first, leave on the last, then update and idle
  task automatic shift(input logic [31:0] din, input int n, output logic [31:0] q);
    logic o;
    q = '0;
    for (int i = 0; i < n; i++) begin
      tester.step(i == n - 1, din[i], o);
      q[i] = o;
    end
    chk(tdoOeN, 1'b0);
    walk(8'h01, 2);
    repeat (8) @(negedge ref_clk); // let pins follow the latch
    chk(tdoOeN, 1'b1);
  endtask
  task automatic load_ir(input logic [4:0] code);
    walk(8'h03, 4);
    shift({27'h0, code}, 5, dout);
    chk(dout[4:0], 5'h01);
    chk(activeInstr, code);
  endtask
  task automatic scan_dr(input logic [31:0] din);
    walk(8'h01, 3);
    shift(din, `CHAIN_LEN, dout);
  endtask
  // one-bit delay from tdi to tdo under a bypass-class code
  task automatic t_bypass(input logic [4:0] code);
    load_ir(code);
    scan_dr(32'h0015A5A3);
    chk(dout[20:0], {20'h5A5A3, 1'b0});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected 150 us of traffic
  initial begin
    #1ms;
    failures++;
    report_and_stop();
  end
  // values left by reset, then out of test-logic-reset into idle
  task automatic t_reset;
    chk(activeInstr, 5'h1F);
    chk({tdoOeN, groupOff, gntPinOeN}, 13'h1000);
    chk({tdoOut, gntPinOut}, {1'b1, 3'h1});
    walk(8'h00, 1);
  endtask
  // codes 0 to 6 and 1F, boundary of the bypass range included
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      load_ir(c == 7 ? 5'h1F : c[4:0]);
    end
  endtask
  // sample captures requests, incoming grant levels and the group slots
  task automatic t_sample;
    load_ir(`IR_SAMPLE);
    scan_dr(32'h0);
    chk(dout[11:0], {3'h5, 9'h1A5});
    chk(dout[20:12], 9'h1FF);
  endtask
  // external test drives grants and group disables from the chain
  task automatic t_extest;
    load_ir(`IR_EXTEST);
    reqPin = 9'h05A;
    scan_dr({11'h0, 9'h0DE, 3'h2, 9'h0});
    chk(groupOff, 9'h0DE);
    chk(gntPinOut, 3'h2);
    chk(gntPinOeN, 3'h0);
    scan_dr({11'h0, 9'h020, 3'h5, 9'h0});
    chk(gntPinOeN, 3'h7);
    chk(dout[20:0], {9'h0DE, 3'h5, 9'h05A});
  endtask
  // clamp keeps the driven values while bypass shifts; highz and bypass
  task automatic t_held;
    t_bypass(`IR_CLAMP);
    chk({groupOff, gntPinOut}, {9'h020, 3'h5});
    t_bypass(`IR_HIGHZ);
    chk({groupOff, gntPinOeN}, {9'h1FF, 3'h7});
    gntCore = 3'h6;
    t_bypass(5'h06);
    t_bypass(5'h1F);
    chk({groupOff, gntPinOut}, {9'h000, 3'h6});
  endtask
  // delay measurement drives the pins from the chain like external test
  task automatic t_delay;
    load_ir(`IR_DELAY);
    scan_dr({11'h0, 9'h001, 3'h3, 9'h0});
    chk(dout[11:0], {3'h5, 9'h05A});
    chk({groupOff, gntPinOut, gntPinOeN}, {9'h001, 3'h3, 3'h0});
  endtask
  // five tms highs from idle return to test-logic-reset
  task automatic t_tms_reset;
    load_ir(`IR_EXTEST);
    walk(8'h1F, 5);
    repeat (8) @(negedge ref_clk);
    chk(activeInstr, 5'h1F);
    walk(8'h00, 1);
  endtask
  // test reset in mid instruction shift, tdo driven at that moment
  task automatic t_trst;
    load_ir(`IR_EXTEST);
    walk(8'h03, 5);
    chk(tdoOeN, 1'b0);
    tester.pulse_reset();
    repeat (4) @(negedge ref_clk);
    chk({activeInstr, tdoOeN}, {5'h1F, 1'b1});
    walk(8'h00, 1);
    load_ir(`IR_SAMPLE);
  endtask
  // main sequence
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    reqPin = 9'h1A5;
    gntCore = 3'h1;
    gntPinIn = 3'h5;
    failures = 0;
    num_checks = 0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_codes();
    t_sample();
    t_extest();
    t_held();
    t_delay();
    t_tms_reset();
    t_trst();
    report_and_stop();
  end
endmodule
`default_nettype wire
